// ---- design/priv_if.sv ----
// privilege level and mode signals shared by the control block's parts
`timescale 1ns/10ps
interface priv_if;
    logic supervisor;
    logic master;
    logic inException;

    modport ctrl (output supervisor, output master, output inException);
    modport view (input supervisor, input master, input inException);
endinterface : priv_if

// ---- design/priv_pkg.sv ----
// shared types and constants for the privilege and state control block
package priv_pkg;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int SW_WIDTH = 16;
    localparam int S_BIT = 13;
    localparam int M_BIT = 12;
    localparam logic [15:0] SW_RESET = 16'h2000;

    // ------------------------------------------------------------
    // address space codes
    // ------------------------------------------------------------
    localparam logic [2:0] FC_USER_DATA = 3'h1;
    localparam logic [2:0] FC_USER_PROG = 3'h2;
    localparam logic [2:0] FC_SUPER_DATA = 3'h5;
    localparam logic [2:0] FC_SUPER_PROG = 3'h6;
    localparam logic [2:0] FC_CPU = 3'h7;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_EXCEPTION = 2'b01,
        ST_HALTED = 2'b10
    } proc_state_type;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_LOAD_STATUS = 4'h1,
        OP_AND_STATUS = 4'h2,
        OP_XOR_STATUS = 4'h3,
        OP_OR_STATUS = 4'h4,
        OP_RETURN = 4'h5,
        OP_STOP = 4'h6,
        OP_RESET = 4'h7,
        OP_PLAIN = 4'h8
    } op_type;

    typedef enum logic [1:0] {
        CYC_DATA = 2'b00,
        CYC_PROGRAM = 2'b01,
        CYC_CPU = 2'b10
    } cycle_type;

    typedef enum logic [1:0] {
        SP_USER = 2'b00,
        SP_TASK = 2'b01,
        SP_IRQ = 2'b10
    } stack_type;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function automatic logic writesStatus(input op_type op);
        return op == OP_LOAD_STATUS || op == OP_AND_STATUS ||
               op == OP_XOR_STATUS || op == OP_OR_STATUS ||
               op == OP_RETURN;
    endfunction : writesStatus

    function automatic logic isPrivileged(input op_type op);
        return writesStatus(op) || op == OP_STOP || op == OP_RESET;
    endfunction : isPrivileged

endpackage : priv_pkg

// ---- design/privilege_state_control.sv ----
// processing state, privilege level and stack mode control
`timescale 1ns/10ps

// Overview of operation
// RL1: always exactly one of normal or exception state, unless halted.
// RL2: interrupts, traps, traces, bus errors, coprocessor faults start exceptions.
// RL3: exception work ends only when the first handler instruction starts.
// RL4: bus or address error during exception work halts the device.
// RL5: halted state persists until external reset; system must apply reset.
// RL6: stop op gives a stopped normal state with no bus cycles.
// RL7: supervisor bit set means supervisor level; clear means user level.
// RL8: user level refuses stop, reset and every status-altering op.
// RL9: bus cycles carry supervisor or user space codes by level.
// RL10: supervisor with master bit set uses the task stack pointer.
// RL11: supervisor with master bit clear uses the irq stack pointer.
// RL12: after reset the master bit is clear.
// RL13: master bit never affects which ops are privileged.
// RL14: master bit changes only by status ops, return, or interrupts.
// RL15: interrupt entry saves the master bit, then clears it.
// RL16: exception work is supervisor level, supervisor cycles and stacks.
// RL17: user level uses the user stack pointer for stack references.
// RL18: exception entry pushes the status word, then sets supervisor bit.
// RL19: exception return restores status word; level follows restored bit.
// RL20: privileged op at user level raises a privilege violation instead.
// RL21: halted state is shown on an output so the system can reset.
module privilege_state_control #(
    parameter int AW = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic instrValid,
    input priv_pkg::op_type instrOp,
    input wire logic [15:0] immData,
    input wire logic [15:0] restoreWord,
    input wire logic exceptReq,
    input wire logic exceptIsIrq,
    input wire logic busError,
    input wire logic addressError,
    input wire logic handlerStart,
    input priv_pkg::cycle_type cycleKind,
    input wire logic spWrite,
    input wire logic [AW-1:0] spData,
    output priv_pkg::proc_state_type procState,
    output logic halted,
    output logic stopped,
    output logic supervisor,
    output logic master,
    output logic [15:0] statusWord,
    output logic [15:0] savedStatus,
    output logic pushStrobe,
    output logic privViolation,
    output logic resetPulse,
    output logic busAllowed,
    output logic [2:0] spaceCode,
    output priv_pkg::stack_type stackSel,
    output logic [AW-1:0] activeSp
);
    priv_if level();

    logic inNormal;
    logic inExc;
    logic fault;
    logic violation;
    logic enterExc;
    logic execOp;
    logic irqEntry;
    logic [15:0] next_status;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign inNormal = procState == priv_pkg::ST_NORMAL;
    assign inExc = procState == priv_pkg::ST_EXCEPTION;
    assign fault = busError || addressError;
    assign supervisor = statusWord[priv_pkg::S_BIT]; // RL7
    assign master = statusWord[priv_pkg::M_BIT];

    // privilege hangs on the supervisor bit alone, never the master bit
    assign violation = inNormal && !stopped && instrValid &&
        !supervisor && priv_pkg::isPrivileged(instrOp); // RL8 RL13
    assign enterExc = inNormal &&
        (exceptReq || fault || violation); // RL2 RL20
    assign irqEntry = enterExc && exceptReq && exceptIsIrq;
    assign execOp = inNormal && !stopped && instrValid && !enterExc;

    // stopped or halted issues no bus cycles
    assign busAllowed = !stopped && !halted; // RL6
    assign halted = procState == priv_pkg::ST_HALTED; // RL21

    assign level.supervisor = supervisor;
    assign level.master = master;
    assign level.inException = inExc;

    // ------------------------------------------------------------
    // processing state
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            procState <= priv_pkg::ST_NORMAL;
        end else begin
            case (procState) // RL1
                priv_pkg::ST_NORMAL: begin
                    if (enterExc) begin
                        procState <= priv_pkg::ST_EXCEPTION; // RL2
                    end
                end
                priv_pkg::ST_EXCEPTION: begin
                    if (fault) begin
                        procState <= priv_pkg::ST_HALTED; // RL4
                    end else if (handlerStart) begin
                        procState <= priv_pkg::ST_NORMAL; // RL3
                    end
                end
                priv_pkg::ST_HALTED: begin
                    procState <= priv_pkg::ST_HALTED; // RL5
                end
                default: begin
                    procState <= priv_pkg::ST_HALTED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    always_comb begin
        next_status = statusWord;
        if (enterExc) begin
            next_status[priv_pkg::S_BIT] = 1'b1; // RL18 RL16
            if (irqEntry) begin
                next_status[priv_pkg::M_BIT] = 1'b0; // RL15
            end
        end else if (execOp) begin
            case (instrOp) // RL14
                priv_pkg::OP_LOAD_STATUS: next_status = immData;
                priv_pkg::OP_AND_STATUS: next_status = statusWord & immData;
                priv_pkg::OP_XOR_STATUS: next_status = statusWord ^ immData;
                priv_pkg::OP_OR_STATUS: next_status = statusWord | immData;
                priv_pkg::OP_RETURN: next_status = restoreWord; // RL19
                default: next_status = statusWord;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            statusWord <= priv_pkg::SW_RESET; // RL12
        end else begin
            statusWord <= next_status;
        end
    end

    // ------------------------------------------------------------
    // frame push
    // ------------------------------------------------------------
    // the old word, both select bits included, is captured before the
    // supervisor bit is forced, so the handler can return to user level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            savedStatus <= '0;
            pushStrobe <= 1'b0;
        end else begin
            pushStrobe <= enterExc;
            if (enterExc) begin
                savedStatus <= statusWord; // RL18 RL15
            end
        end
    end

    // ------------------------------------------------------------
    // stop condition
    // ------------------------------------------------------------
    // only an exception wakes a stopped device; a halt needs reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stopped <= 1'b0;
        end else if (enterExc || !inNormal) begin
            stopped <= 1'b0;
        end else if (execOp && instrOp == priv_pkg::OP_STOP) begin
            stopped <= 1'b1; // RL6
        end
    end

    // ------------------------------------------------------------
    // event pulses
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            privViolation <= 1'b0;
            resetPulse <= 1'b0;
        end else begin
            privViolation <= violation; // RL20
            resetPulse <= execOp && instrOp == priv_pkg::OP_RESET;
        end
    end

    // ------------------------------------------------------------
    // parts
    // ------------------------------------------------------------
    space_code_gen spaceGen (
        .clock(clock),
        .rst(rst),
        .level(level.view),
        .cycleKind(cycleKind),
        .spaceCode(spaceCode)
    );

    stack_select #(.AW(AW)) stackPick (
        .clock(clock),
        .rst(rst),
        .level(level.view),
        .spWrite(spWrite),
        .spData(spData),
        .stackSel(stackSel),
        .activeSp(activeSp)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence faultInException;
        inExc && fault;
    endsequence

    sequence userPrivOp;
        violation ##1 privViolation;
    endsequence

    sequence irqEnter;
        inNormal && exceptReq && exceptIsIrq;
    endsequence

    a_halt_on_fault: assert property (@(posedge clock) disable iff (rst) // RL4
        faultInException |=> halted ##1 halted)
        else $error("fault in exception work did not halt");
    a_halt_holds: assert property (@(posedge clock) disable iff (rst) // RL5
        halted |=> halted && !busAllowed)
        else $error("left the halted state without reset");
    a_exc_supervisor: assert property (@(posedge clock) disable iff (rst) // RL16
        $rose(inExc) |-> supervisor && $past(pushStrobe == 1'b0))
        else $error("exception work not at supervisor level");
    a_irq_master: assert property (@(posedge clock) disable iff (rst) // RL15
        irqEnter |=> !master && savedStatus == $past(statusWord))
        else $error("interrupt entry did not save and clear master");
    a_priv_refused: assert property (@(posedge clock) disable iff (rst) // RL20
        userPrivOp |-> inExc && statusWord[priv_pkg::S_BIT]
            && savedStatus[priv_pkg::S_BIT] == 1'b0)
        else $error("user privileged op was not refused");
    a_master_source: assert property (@(posedge clock) disable iff (rst) // RL14
        $changed(master) |-> $past(irqEntry || (execOp &&
            priv_pkg::writesStatus(instrOp))))
        else $error("master bit changed without a legal cause");
    a_handler_done: assert property (@(posedge clock) disable iff (rst) // RL3
        (inExc && !fault && !handlerStart) |=> inExc || halted)
        else $error("exception work ended before handler start");
    a_stop_quiet: assert property (@(posedge clock) disable iff (rst) // RL6
        (execOp && instrOp == priv_pkg::OP_STOP)
        |=> stopped && !busAllowed && inNormal)
        else $error("stop op did not stop bus cycles");
endmodule : privilege_state_control

// ---- design/space_code_gen.sv ----
// classification of each bus cycle into an address space code
`timescale 1ns/10ps
module space_code_gen (
    input wire logic clock,
    input wire logic rst,
    priv_if.view level,
    input priv_pkg::cycle_type cycleKind,
    output logic [2:0] spaceCode
);
    logic superRef;

    // exception work is always a supervisor reference
    assign superRef = level.supervisor || level.inException; // RL16

    // ------------------------------------------------------------
    // code register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            spaceCode <= priv_pkg::FC_SUPER_PROG;
        end else begin
            case (cycleKind)
                priv_pkg::CYC_CPU: spaceCode <= priv_pkg::FC_CPU;
                priv_pkg::CYC_PROGRAM: spaceCode <= superRef ?
                    priv_pkg::FC_SUPER_PROG : priv_pkg::FC_USER_PROG; // RL9
                default: spaceCode <= superRef ?
                    priv_pkg::FC_SUPER_DATA : priv_pkg::FC_USER_DATA; // RL9
            endcase
        end
    end

    a_space_user: assert property (@(posedge clock) disable iff (rst) // RL9
        (!superRef && cycleKind != priv_pkg::CYC_CPU) |=> !spaceCode[2])
        else $error("user cycle got a supervisor code");
    a_space_super: assert property (@(posedge clock) disable iff (rst) // RL16
        superRef |=> spaceCode[2])
        else $error("supervisor cycle got a user code");
endmodule : space_code_gen

// ---- design/stack_select.sv ----
// choice of the active stack pointer and storage of the three pointers
`timescale 1ns/10ps
module stack_select #(
    parameter int AW = 32
) (
    input wire logic clock,
    input wire logic rst,
    priv_if.view level,
    input wire logic spWrite,
    input wire logic [AW-1:0] spData,
    output priv_pkg::stack_type stackSel,
    output logic [AW-1:0] activeSp
);
    logic [AW-1:0] pointers [3];
    priv_pkg::stack_type next_sel;

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    always_comb begin
        if (!level.supervisor && !level.inException) begin
            next_sel = priv_pkg::SP_USER; // RL17
        end else if (level.master) begin
            next_sel = priv_pkg::SP_TASK; // RL10
        end else begin
            next_sel = priv_pkg::SP_IRQ; // RL11
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stackSel <= priv_pkg::SP_IRQ;
        end else begin
            stackSel <= next_sel;
        end
    end

    // ------------------------------------------------------------
    // pointer storage
    // ------------------------------------------------------------
    // writes go to next_sel, the pointer the current level picks, ahead of the
    // registered stackSel, so a write just after a level change lands in the new pointer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pointers[0] <= '0;
            pointers[1] <= '0;
            pointers[2] <= '0;
        end else if (spWrite) begin
            pointers[next_sel] <= spData;
        end
    end

    assign activeSp = pointers[stackSel];

    a_stack_master: assert property (@(posedge clock) disable iff (rst) // RL10
        (level.supervisor && level.master) |=> stackSel == priv_pkg::SP_TASK)
        else $error("master mode did not use the task stack");
    a_stack_user: assert property (@(posedge clock) disable iff (rst) // RL17
        (!level.supervisor && !level.inException)
        |=> stackSel == priv_pkg::SP_USER)
        else $error("user level did not use the user stack");
endmodule : stack_select

// ---- verification/bus_partner.sv ----
// memory side partner: issues bus cycle kinds and returns bus faults
`timescale 1ns/10ps
module bus_partner (
    input wire logic busAllowed,
    input priv_pkg::cycle_type kindCmd,
    input wire logic faultCmd,
    output priv_pkg::cycle_type cycleKind,
    output logic busError
);
    // ------------------------------------------------------------
    // cycle issue
    // ------------------------------------------------------------
    // no cycle runs while the bus is refused, so idle reads as data
    // and no bus error can come back without a cycle to end
    always_comb begin
        cycleKind = busAllowed ? kindCmd : priv_pkg::CYC_DATA;
        busError = faultCmd && busAllowed;
    end
endmodule : bus_partner

// ---- verification/tb_privilege_state_control.sv ----
// self-checking bench for the privilege and state control block
`timescale 1ns/10ps
module tb_privilege_state_control;
    logic clock, rst, instrValid, exceptReq, exceptIsIrq, addressError;
    logic handlerStart, spWrite, faultCmd, busError;
    logic halted, stopped, supervisor, master, pushStrobe, privViolation;
    logic resetPulse, busAllowed;
    logic [15:0] immData, restoreWord, statusWord, savedStatus;
    logic [31:0] spData, activeSp;
    logic [2:0] spaceCode;
    priv_pkg::op_type instrOp;
    priv_pkg::cycle_type kindCmd, cycleKind;
    priv_pkg::proc_state_type procState;
    priv_pkg::stack_type stackSel;
    int fail_count;
    int n_tests;

    privilege_state_control DUT (
        .clock(clock), .rst(rst), .instrValid(instrValid),
        .instrOp(instrOp), .immData(immData), .restoreWord(restoreWord),
        .exceptReq(exceptReq), .exceptIsIrq(exceptIsIrq),
        .busError(busError), .addressError(addressError),
        .handlerStart(handlerStart), .cycleKind(cycleKind),
        .spWrite(spWrite), .spData(spData), .procState(procState),
        .halted(halted), .stopped(stopped), .supervisor(supervisor),
        .master(master), .statusWord(statusWord),
        .savedStatus(savedStatus), .pushStrobe(pushStrobe),
        .privViolation(privViolation), .resetPulse(resetPulse),
        .busAllowed(busAllowed), .spaceCode(spaceCode),
        .stackSel(stackSel), .activeSp(activeSp)
    );

    bus_partner partner (
        .busAllowed(busAllowed), .kindCmd(kindCmd), .faultCmd(faultCmd),
        .cycleKind(cycleKind), .busError(busError)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step

    // one idle edge first, so back-to-back ops never retoggle a strobe
    task automatic op(input priv_pkg::op_type o, input logic [15:0] imm);
        step(1);
        instrValid = 1'b1;
        instrOp = o;
        immData = imm;
        restoreWord = imm;
        step(1);
        instrValid = 1'b0;
    endtask : op

    // bounded wait: entry comes on the same edge that samples a refused op
    task automatic wait_exc;
        for (int i = 0; i < 8 && procState !== priv_pkg::ST_EXCEPTION; i++)
            step(1);
        chk(procState, priv_pkg::ST_EXCEPTION);
    endtask : wait_exc

    task automatic raise(input logic irq);
        exceptReq = 1'b1;
        exceptIsIrq = irq;
        step(1);
        exceptReq = 1'b0;
        exceptIsIrq = 1'b0;
        wait_exc();
    endtask : raise

    task automatic handler;
        handlerStart = 1'b1;
        step(1);
        handlerStart = 1'b0;
        chk(procState, priv_pkg::ST_NORMAL);
    endtask : handler

    // counts rising edges, so the clock's first step from x cannot
    // shorten the reset at time zero
    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        step(1);
        rst = 1'b0;
        step(1);
    endtask : do_reset

    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        chk(statusWord, priv_pkg::SW_RESET);
        chk(master, 1'b0);
        chk(procState, priv_pkg::ST_NORMAL);
        chk(halted, 1'b0);
        chk(stackSel, priv_pkg::SP_IRQ);
        kindCmd = priv_pkg::CYC_CPU;
        step(2);
        chk(spaceCode, priv_pkg::FC_CPU);
        kindCmd = priv_pkg::CYC_DATA;
        step(2);
        chk(spaceCode, priv_pkg::FC_SUPER_DATA);
    endtask : t_reset_values

    task automatic t_status_ops;
        op(priv_pkg::OP_OR_STATUS, 16'h1000);
        chk(statusWord, 16'h3000);
        step(2);
        chk(stackSel, priv_pkg::SP_TASK);
        spWrite = 1'b1;
        spData = 32'h0000_0100;
        step(1);
        spWrite = 1'b0;
        chk(activeSp, 32'h0000_0100);
        op(priv_pkg::OP_AND_STATUS, 16'hEFFF);
        chk(statusWord, 16'h2000);
        step(2);
        chk(stackSel, priv_pkg::SP_IRQ);
        chk(activeSp, 32'h0000_0000);
        op(priv_pkg::OP_XOR_STATUS, 16'h1000);
        chk(statusWord, 16'h3000);
        op(priv_pkg::OP_LOAD_STATUS, 16'h2000);
        chk(statusWord, 16'h2000);
        op(priv_pkg::OP_RETURN, 16'h0000);
        chk(supervisor, 1'b0);
        kindCmd = priv_pkg::CYC_PROGRAM;
        step(3);
        chk(stackSel, priv_pkg::SP_USER);
        chk(spaceCode, priv_pkg::FC_USER_PROG);
        kindCmd = priv_pkg::CYC_DATA;
        step(3);
        chk(spaceCode, priv_pkg::FC_USER_DATA);
        op(priv_pkg::OP_PLAIN, 16'h0000);
        chk(privViolation, 1'b0);
    endtask : t_status_ops

    // every privileged op refused at user level, master left clear
    task automatic t_refusals;
        priv_pkg::op_type ops[7];
        ops = '{priv_pkg::OP_LOAD_STATUS, priv_pkg::OP_AND_STATUS,
                priv_pkg::OP_XOR_STATUS, priv_pkg::OP_OR_STATUS,
                priv_pkg::OP_RETURN, priv_pkg::OP_STOP, priv_pkg::OP_RESET};
        foreach (ops[i]) begin
            op(ops[i], 16'h1000);
            chk(privViolation, 1'b1);
            chk(resetPulse, 1'b0);
            chk(stopped, 1'b0);
            wait_exc();
            chk(pushStrobe, 1'b1);
            chk(savedStatus, 16'h0000);
            chk(statusWord, 16'h2000);
            kindCmd = priv_pkg::CYC_PROGRAM;
            step(2);
            chk(spaceCode, priv_pkg::FC_SUPER_PROG);
            chk(stackSel, priv_pkg::SP_IRQ);
            handler();
            op(priv_pkg::OP_RETURN, 16'h0000);
        end
    endtask : t_refusals

    task automatic t_interrupt;
        raise(1'b0);
        chk(supervisor, 1'b1);
        handler();
        op(priv_pkg::OP_OR_STATUS, 16'h1000);
        raise(1'b1);
        chk(master, 1'b0);
        chk(savedStatus, 16'h3000);
        handler();
        op(priv_pkg::OP_OR_STATUS, 16'h1000);
        raise(1'b0);
        chk(master, 1'b1);
        chk(supervisor, 1'b1);
        handler();
    endtask : t_interrupt

    task automatic t_stop_and_reset_op;
        op(priv_pkg::OP_LOAD_STATUS, 16'h2000);
        op(priv_pkg::OP_RESET, 16'h0000);
        chk(resetPulse, 1'b1);
        step(1);
        chk(resetPulse, 1'b0);
        op(priv_pkg::OP_STOP, 16'h0000);
        chk(stopped, 1'b1);
        chk(busAllowed, 1'b0);
        chk(halted, 1'b0);
        op(priv_pkg::OP_OR_STATUS, 16'h1000);
        chk(statusWord, 16'h2000);
        raise(1'b0);
        chk(stopped, 1'b0);
        handler();
    endtask : t_stop_and_reset_op

    // a fault while stacking halts; only reset brings the block back
    task automatic t_halt(input logic useAddr);
        faultCmd = 1'b1;
        step(1);
        faultCmd = 1'b0;
        wait_exc();
        chk(halted, 1'b0);
        step(1);
        faultCmd = !useAddr;
        addressError = useAddr;
        step(1);
        faultCmd = 1'b0;
        addressError = 1'b0;
        for (int i = 0; i < 4 && halted !== 1'b1; i++)
            step(1);
        chk(halted, 1'b1);
        chk(procState, priv_pkg::ST_HALTED);
        handlerStart = 1'b1;
        exceptReq = 1'b1;
        step(5);
        handlerStart = 1'b0;
        exceptReq = 1'b0;
        chk(halted, 1'b1);
        chk(busAllowed, 1'b0);
        do_reset();
        chk(halted, 1'b0);
        chk(master, 1'b0);
    endtask : t_halt

    // ------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        {instrValid, exceptReq, exceptIsIrq, addressError} = 4'h0;
        {handlerStart, spWrite, faultCmd} = 3'h0;
        instrOp = priv_pkg::OP_NONE;
        immData = 16'h0000;
        restoreWord = 16'h0000;
        spData = 32'h0000_0000;
        kindCmd = priv_pkg::CYC_PROGRAM;
        fail_count = 0;
        n_tests = 0;
        do_reset();
        t_reset_values();
        t_status_ops();
        t_refusals();
        t_interrupt();
        t_stop_and_reset_op();
        t_halt(1'b0);
        t_halt(1'b1);
        end_sim();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        #(25 * 4000);
        fail_count++;
        end_sim();
    end
endmodule : tb_privilege_state_control
